// file: rtl/pbs_consts.svh
// Constants of the polling and bit-check sequencer.
// Assumes inclusion by bare name from each design file that uses its constants.
`ifndef PBS_CONSTS_SVH
`define PBS_CONSTS_SVH
`define PBS_DIV_A 5'd28
`define PBS_DIV_B 5'd30
`define PBS_SLEEP_UNIT 11'd1024
`define PBS_SLEEP_MAX 5'h1f
`define PBS_XSLEEP_EXT 4'd8
`define PBS_XSLEEP_STD 4'd1
`define PBS_STARTUP_TICKS 16'h0100
`define PBS_ADDR_OPERATING_CONFIG_REG 12'h000
`define PBS_ADDR_LIMIT 12'h004
`define PBS_ADDR_STATUS 12'h008
`define PBS_OPERATING_CONFIG_REG_RESET 32'h0000_0000
`define PBS_LIMIT_RESET 32'h0000_0000
`define PBS_OP_SLEEP_LSB 0
`define PBS_OP_XSLEEP_BIT 5
`define PBS_OP_NBIT_LSB 6
`define PBS_OP_BR_LSB 8
`define PBS_OP_VARIANT_BIT 10
`define PBS_LIM_MIN_LSB 0
`define PBS_LIM_MAX_LSB 8
`endif

// file: rtl/pbs_pkg.sv
// Types of the polling and bit-check sequencer.
// Assumes nothing of its surroundings.
package pbs_pkg;
	typedef enum logic [2:0]
	{
		PBS_SLEEP = 3'b000,
		PBS_STARTUP = 3'b001,
		PBS_CHECK = 3'b010,
		PBS_RECEIVE = 3'b011,
		PBS_PARKED = 3'b100
	} pbs_state_e;
endpackage

// file: rtl/pbs_divider.sv
// Programmable tick divider: one-cycle pulse every ratio enables.
// Assumes ratio is at least one and stable between uses.
`timescale 1ns/1ps
`include "pbs_consts.svh"
module pbs_divider
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic en,
	input wire logic [4:0] ratio,
	output logic tick
);
	logic [4:0] cnt;
	// Count enables; pulse at terminal count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt <= 5'h00;
		else if (en)
			cnt <= (cnt + 5'h01 >= ratio) ? 5'h00 : cnt + 5'h01;
	end
	assign tick = en && (cnt + 5'h01 >= ratio);
endmodule

// file: rtl/pbs_apb_regs.sv
// APB slave holding operating and limit configuration plus status.
// Assumes a standard APB master; zero wait states.
`timescale 1ns/1ps
`include "pbs_consts.svh"
module pbs_apb_regs
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] status,
	output logic [31:0] operating_config_reg,
	output logic [31:0] limit_config_reg,
	output logic op_written
);
	logic wr;
	logic hit;
	assign wr = psel && penable && pwrite;
	assign hit = (paddr == `PBS_ADDR_OPERATING_CONFIG_REG) || (paddr == `PBS_ADDR_LIMIT) || (paddr == `PBS_ADDR_STATUS);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	// Configuration writes; status is read-only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			operating_config_reg <= `PBS_OPERATING_CONFIG_REG_RESET;
			limit_config_reg <= `PBS_LIMIT_RESET;
			op_written <= 1'b0;
		end
		else
		begin
			op_written <= wr && (paddr == `PBS_ADDR_OPERATING_CONFIG_REG);
			if (wr && paddr == `PBS_ADDR_OPERATING_CONFIG_REG)
				operating_config_reg <= pwdata & 32'h0000_07ff;
			if (wr && paddr == `PBS_ADDR_LIMIT)
				limit_config_reg <= pwdata & 32'h0000_3f1f;
		end
	end
	// Registered read data, loaded in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
		begin
			case (paddr)
				`PBS_ADDR_OPERATING_CONFIG_REG: prdata <= operating_config_reg;
				`PBS_ADDR_LIMIT: prdata <= limit_config_reg;
				`PBS_ADDR_STATUS: prdata <= status;
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// file: rtl/pbs_sequencer.sv
// Polling and bit-check sequencer top: sleep, start-up, bit-check, receive.
// Assumes pclk is the crystal clock and dem_out is synchronous to it.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "pbs_consts.svh"
module pbs_sequencer
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic dem_out,
	input wire logic polling_cmd,
	output logic activity_indicator,
	output logic path_enable,
	output logic data_out
);
	// ------------------------------------------------------------
	// Registers and configuration fields
	// ------------------------------------------------------------
	logic [31:0] operating_config_reg;
	logic [31:0] limit_config_reg;
	logic [31:0] status;
	logic op_written;
	logic [4:0] sleep_field;
	logic sleep_extend_bit;
	logic [1:0] nbit_sel;
	logic [1:0] baud_range_select;
	logic variant_sel;
	logic [4:0] lim_min;
	logic [5:0] lim_max;
	pbs_pkg::pbs_state_e state;
	pbs_pkg::pbs_state_e next_state;

	assign sleep_field = operating_config_reg[`PBS_OP_SLEEP_LSB +: 5];
	assign sleep_extend_bit = operating_config_reg[`PBS_OP_XSLEEP_BIT];
	assign nbit_sel = operating_config_reg[`PBS_OP_NBIT_LSB +: 2];
	assign baud_range_select = operating_config_reg[`PBS_OP_BR_LSB +: 2];
	assign variant_sel = operating_config_reg[`PBS_OP_VARIANT_BIT];
	assign lim_min = limit_config_reg[`PBS_LIM_MIN_LSB +: 5];
	assign lim_max = limit_config_reg[`PBS_LIM_MAX_LSB +: 6];

	pbs_apb_regs u_regs
	(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.status(status),
		.operating_config_reg(operating_config_reg),
		.limit_config_reg(limit_config_reg),
		.op_written(op_written)
	);

	// ------------------------------------------------------------
	// Tick generation
	// ------------------------------------------------------------
	logic basic_tick;
	logic extended_tick;
	logic [4:0] basic_ratio;
	logic [4:0] ext_ratio;
	// divide by 28 or 30 per variant
	assign basic_ratio = variant_sel ? `PBS_DIV_B : `PBS_DIV_A;
	// range 1 four, range 2 two, range 3 one basic tick
	always_comb
	begin
		case (baud_range_select)
			2'd1: ext_ratio = 5'd2;
			2'd2: ext_ratio = 5'd1;
			default: ext_ratio = 5'd4;
		endcase
	end

	pbs_divider u_basic
	(
		.pclk(pclk),
		.presetn(presetn),
		.en(1'b1),
		.ratio(basic_ratio),
		.tick(basic_tick)
	);
	pbs_divider u_ext
	(
		.pclk(pclk),
		.presetn(presetn),
		.en(basic_tick),
		.ratio(ext_ratio),
		.tick(extended_tick)
	);

	// ------------------------------------------------------------
	// Timers and edge detection
	// ------------------------------------------------------------
	logic [18:0] sleep_target;
	logic [18:0] phase_cnt;
	logic [5:0] interval_count_value;
	logic [4:0] checks_done;
	logic [4:0] checks_needed;
	logic dem_sync;
	logic dem_prev;
	logic dem_edge;
	logic sleep_done;
	logic startup_done;
	logic check_fail;
	logic check_pass;
	logic first_seen;

	// sleep in basic ticks: field x multiplier x 1024
	assign sleep_target = 19'(sleep_field) * 19'(sleep_extend_bit ? `PBS_XSLEEP_EXT : `PBS_XSLEEP_STD)
		* 19'(`PBS_SLEEP_UNIT);
	assign sleep_done = basic_tick && (phase_cnt + 19'd1 >= sleep_target);
	assign startup_done = basic_tick && (phase_cnt + 19'd1 >= 19'(`PBS_STARTUP_TICKS));

	// 0/3/6/9 bits map to 0/6/12/18 checks
	always_comb
	begin
		case (nbit_sel)
			2'd1: checks_needed = 5'd6;
			2'd2: checks_needed = 5'd12;
			2'd3: checks_needed = 5'd18;
			default: checks_needed = 5'd0;
		endcase
	end

	// sample demodulator on extended tick, reset history at check start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dem_sync <= 1'b0;
			dem_prev <= 1'b0;
		end
		else if (state != pbs_pkg::PBS_CHECK)
		begin
			dem_sync <= dem_out;
			dem_prev <= dem_out;
		end
		else if (extended_tick)
		begin
			dem_sync <= dem_out;
			dem_prev <= dem_sync;
		end
	end
	assign dem_edge = extended_tick && (dem_sync != dem_prev);

	// edge below min, or count reaching max, fails
	// The first edge has no earlier edge to measure from, so it only starts the count
	assign check_fail = (state == pbs_pkg::PBS_CHECK)
		&& ((dem_edge && first_seen && interval_count_value < 6'(lim_min)) || (interval_count_value >= lim_max));
	// pass when all configured checks succeeded
	assign check_pass = (state == pbs_pkg::PBS_CHECK) && !check_fail && (checks_done >= checks_needed);

	// Phase timer in basic ticks, restarted on each state change
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_cnt <= 19'd0;
		else if (next_state != state)
			phase_cnt <= 19'd0;
		else if (basic_tick)
			phase_cnt <= phase_cnt + 19'd1;
	end

	// first edge in a check only opens the first interval
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			first_seen <= 1'b0;
		else if (state != pbs_pkg::PBS_CHECK)
			first_seen <= 1'b0;
		else if (dem_edge)
			first_seen <= 1'b1;
	end

	// interval counter per extended tick, set to 1 at each edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			interval_count_value <= 6'd0;
			checks_done <= 5'd0;
		end
		else if (state != pbs_pkg::PBS_CHECK)
		begin
			interval_count_value <= 6'd0;
			checks_done <= 5'd0;
		end
		else if (dem_edge)
		begin
			interval_count_value <= 6'd1;
			if (first_seen)
				checks_done <= checks_done + 5'd1;
		end
		else if (extended_tick && interval_count_value != 6'h3f)
			interval_count_value <= interval_count_value + 6'd1;
	end

	// ------------------------------------------------------------
	// Polling state machine
	// ------------------------------------------------------------
	// Next phase of the polling loop
	always_comb
	begin
		next_state = state;
		case (state)
			pbs_pkg::PBS_SLEEP:
			begin
				if (sleep_field == `PBS_SLEEP_MAX)
					next_state = pbs_pkg::PBS_PARKED;
				else if (sleep_target == 19'd0 || sleep_done)
					next_state = pbs_pkg::PBS_STARTUP;
			end
			pbs_pkg::PBS_STARTUP:
			begin
				if (startup_done)
					next_state = pbs_pkg::PBS_CHECK;
			end
			pbs_pkg::PBS_CHECK:
			begin
				// abort to sleep on window violation
				if (check_fail)
					next_state = pbs_pkg::PBS_SLEEP;
				else if (check_pass)
					next_state = pbs_pkg::PBS_RECEIVE;
			end
			pbs_pkg::PBS_RECEIVE:
			begin
				if (polling_cmd)
					next_state = pbs_pkg::PBS_SLEEP;
			end
			pbs_pkg::PBS_PARKED:
			begin
				// new non-maximum value restarts with fresh sleep
				if (op_written && sleep_field != `PBS_SLEEP_MAX)
					next_state = pbs_pkg::PBS_SLEEP;
			end
			default: next_state = pbs_pkg::PBS_SLEEP;
		endcase
	end

	// Phase register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= pbs_pkg::PBS_SLEEP;
		else
			state <= next_state;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// registered path enable, activity and data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			path_enable <= 1'b0;
			activity_indicator <= 1'b0;
			data_out <= 1'b1;
		end
		else
		begin
			path_enable <= (next_state == pbs_pkg::PBS_STARTUP) || (next_state == pbs_pkg::PBS_CHECK)
				|| (next_state == pbs_pkg::PBS_RECEIVE);
			activity_indicator <= (next_state == pbs_pkg::PBS_STARTUP) || (next_state == pbs_pkg::PBS_CHECK)
				|| (next_state == pbs_pkg::PBS_RECEIVE);
			data_out <= (next_state == pbs_pkg::PBS_RECEIVE) ? dem_sync : 1'b1;
		end
	end

	assign status = {21'h00_0000, 2'(checks_done >> 3), interval_count_value, state};

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// One clock domain, so the defaults serve every property below
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	fail_to_sleep_a: assert property (check_fail |=> state == pbs_pkg::PBS_SLEEP)
		else $error("Failed check did not return to sleep");
	pass_to_rx_a: assert property (check_pass |=> state == pbs_pkg::PBS_RECEIVE)
		else $error("Passed check did not enter receive");
	rx_hold_a: assert property (state == pbs_pkg::PBS_RECEIVE && !polling_cmd |=> state == pbs_pkg::PBS_RECEIVE)
		else $error("Receive mode left without command");
	park_max_a: assert property (state == pbs_pkg::PBS_SLEEP && sleep_field == `PBS_SLEEP_MAX |=>
		state == pbs_pkg::PBS_PARKED)
		else $error("Maximum sleep did not park");
	activity_map_a: assert property (activity_indicator ==
		(state != pbs_pkg::PBS_SLEEP && state != pbs_pkg::PBS_PARKED))
		else $error("Activity indicator wrong");
	upper_fail_a: assert property (state == pbs_pkg::PBS_CHECK && interval_count_value >= lim_max |->
		check_fail)
		else $error("Upper limit not enforced");
	ext_one_a: assert property (baud_range_select == 2'd2 && basic_tick |-> extended_tick)
		else $error("Range 3 extended tick mismatch");
	basic_gap_a: assert property (basic_tick |=> !basic_tick [*8])
		else $error("Basic tick too frequent");
	sleep_path_a: assert property (state == pbs_pkg::PBS_SLEEP && $past(state) == pbs_pkg::PBS_SLEEP |->
		!path_enable)
		else $error("Path enabled during sleep");
	lower_fail_a: assert property (state == pbs_pkg::PBS_CHECK && dem_edge && first_seen
		&& interval_count_value < 6'(lim_min) |-> check_fail)
		else $error("Short interval not rejected");
	first_edge_a: assert property (state == pbs_pkg::PBS_CHECK && dem_edge && !first_seen
		&& interval_count_value < lim_max |-> !check_fail)
		else $error("First edge wrongly judged");
	count_step_a: assert property (state == pbs_pkg::PBS_CHECK && next_state == pbs_pkg::PBS_CHECK
		&& extended_tick && !dem_edge && interval_count_value != 6'h3f
		|=> interval_count_value == $past(interval_count_value) + 6'd1)
		else $error("Interval counter did not step");

	rx_entry_c: cover property (check_pass);
	fail_c: cover property (check_fail);
	park_c: cover property (state == pbs_pkg::PBS_PARKED);
	resume_c: cover property (state == pbs_pkg::PBS_PARKED ##1 state == pbs_pkg::PBS_SLEEP);
endmodule

// file: testbench/pbs_dem_source.sv
// Stand-in for the demodulator output seen by the sequencer: a square wave.
// Assumes the bench picks the half period and the level held while stopped.
`timescale 1ns/1ps
module pbs_dem_source
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic en,
	input wire logic idle_level,
	input wire logic [15:0] half_cycles,
	output logic dem_out
);
	logic [15:0] cnt;

	// --------------------------------------------------
	// Wave generation
	// --------------------------------------------------
	// Stopped source holds the chosen level so the receive path can be probed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 16'h0000;
			dem_out <= 1'b1;
		end
		else if (!en)
		begin
			cnt <= 16'h0000;
			dem_out <= idle_level;
		end
		else if (cnt >= half_cycles - 16'h0001)
		begin
			cnt <= 16'h0000;
			dem_out <= ~dem_out;
		end
		else
		begin
			cnt <= cnt + 16'h0001;
		end
	end
endmodule

// file: testbench/pbs_sequencer_tb.sv
// Self-checking bench of the polling and bit-check sequencer.
// Assumes variant /28, baud field 2 (extended tick = basic tick = 28 clocks).
`timescale 1ns/1ps
`include "pbs_consts.svh"
module pbs_sequencer_tb;
	localparam int TICK = 28;
	localparam int SLEEP1 = 1024 * TICK;
	localparam int STARTUP = 256 * TICK;
	localparam int CEILING = 95000;
	logic pclk, presetn, psel, penable, pwrite, polling_cmd, src_en, src_idle;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err, dem_out, activity_indicator, path_enable, data_out;
	logic [15:0] half_cycles;
	int failures, n_compared, cycles, n;

	pbs_sequencer pbs_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dem_out(dem_out), .polling_cmd(polling_cmd),
		.activity_indicator(activity_indicator), .path_enable(path_enable), .data_out(data_out));
	pbs_dem_source pbs_dem_source_inst (.pclk(pclk), .presetn(presetn), .en(src_en),
		.idle_level(src_idle), .half_cycles(half_cycles), .dem_out(dem_out));

	// --------------------------------------------------
	// Clock, timeout and shared tasks
	// --------------------------------------------------
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Hang guard: a stuck wait would otherwise never reach the report
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == CEILING)
		begin
			failures++;
			$display("Error at %0t: run timed out", $time);
			summarize();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Access phase lasts until pready is seen high; only the hang guard ends a stuck wait
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Counts clocks until the activity indicator shows the wanted level
	task automatic wait_act(input logic lvl, input int limit);
		n = 0;
		while (activity_indicator !== lvl && n < limit)
		begin
			@(posedge pclk);
			n++;
		end
		check(32'(n < limit), 32'h0000_0001, "activity wait bounded");
	endtask

	task automatic summarize();
		$display("Compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// --------------------------------------------------
	// Scenarios
	// --------------------------------------------------
	task automatic reset_values();
		apb(1'b0, `PBS_ADDR_OPERATING_CONFIG_REG, 32'h0000_0000);
		check(rd, `PBS_OPERATING_CONFIG_REG_RESET, "operating_config_reg reset");
		apb(1'b0, `PBS_ADDR_LIMIT, 32'h0000_0000);
		check(rd, `PBS_LIMIT_RESET, "limit reset");
		apb(1'b0, 12'h00c, 32'h0000_0000);
		check(rd, 32'h0000_0000, "unmapped read data");
		check(32'(err), 32'h0000_0001, "unmapped read error");
		apb(1'b0, `PBS_ADDR_STATUS, 32'h0000_0000);
		check(32'(rd[2:0]), 32'h0000_0001, "zero sleep starts up");
		check(32'({activity_indicator, path_enable}), 32'h0000_0003, "active in start-up");
		check(32'(data_out), 32'h0000_0001, "data idle before receive");
	endtask

	// Edges every 14 ticks sit inside lower 10 and upper 20-1
	task automatic good_check();
		apb(1'b1, `PBS_ADDR_LIMIT, 32'h0000_140a);
		apb(1'b0, `PBS_ADDR_LIMIT, 32'h0000_0000);
		check(rd, 32'h0000_140a, "limit readback");
		apb(1'b1, `PBS_ADDR_OPERATING_CONFIG_REG, 32'h0000_0240);
		half_cycles <= 16'(14 * TICK);
		src_en <= 1'b1;
		rd = 32'h0000_0000;
		for (int i = 0; i < 5000 && rd[2:0] !== 3'd3; i++)
			apb(1'b0, `PBS_ADDR_STATUS, 32'h0000_0000);
		check(32'(rd[2:0]), 32'h0000_0003, "receive entered");
		check(32'({activity_indicator, path_enable}), 32'h0000_0003, "active in receive");
		src_en <= 1'b0;
		src_idle <= 1'b0;
		repeat (300) @(posedge pclk);
		check(32'(data_out), 32'h0000_0000, "demod routed out");
		apb(1'b0, `PBS_ADDR_STATUS, 32'h0000_0000);
		check(32'(rd[2:0]), 32'h0000_0003, "receive held");
	endtask

	task automatic parked();
		apb(1'b1, `PBS_ADDR_OPERATING_CONFIG_REG, 32'h0000_025f);
		polling_cmd <= 1'b1;
		repeat (4) @(posedge pclk);
		polling_cmd <= 1'b0;
		repeat (2000) @(posedge pclk);
		apb(1'b0, `PBS_ADDR_STATUS, 32'h0000_0000);
		check(32'(rd[2:0]), 32'h0000_0004, "permanent sleep");
		check(32'({activity_indicator, path_enable}), 32'h0000_0000, "idle while parked");
	endtask

	// Edges every 5 ticks fall below the lower limit, so each check aborts
	task automatic failing_check();
		int t_start;
		half_cycles <= 16'(5 * TICK);
		src_en <= 1'b1;
		apb(1'b1, `PBS_ADDR_OPERATING_CONFIG_REG, 32'h0000_0241);
		apb(1'b0, `PBS_ADDR_STATUS, 32'h0000_0000);
		check(32'(rd[2:0]), 32'h0000_0000, "restart into sleep");
		wait_act(1'b1, 40000);
		check(32'(n + 6 > SLEEP1 - 60 && n + 6 < SLEEP1 + 60), 32'h0000_0001, "sleep length");
		wait_act(1'b0, 12000);
		t_start = n;
		check(32'(t_start >= STARTUP), 32'h0000_0001, "start-up edges ignored");
		check(32'(path_enable), 32'h0000_0000, "path off in sleep");
		wait_act(1'b1, 40000);
		check(32'(n > SLEEP1 - 60 && n < SLEEP1 + 60), 32'h0000_0001, "sleep after abort");
	endtask

	// --------------------------------------------------
	// Main sequence
	// --------------------------------------------------
	initial
	begin
		failures = 0;
		n_compared = 0;
		cycles = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		polling_cmd = 1'b0;
		src_en = 1'b0;
		src_idle = 1'b1;
		half_cycles = 16'h0100;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		reset_values();
		good_check();
		parked();
		failing_check();
		summarize();
	end
endmodule
